// [src/mtt_defines.svh]
`ifndef MTT_DEFINES_SVH
`define MTT_DEFINES_SVH

// bus geometry of the memory under test
`define MTT_DW 8
`define MTT_AW 8
// step counter width, enough for every address bit plus address zero
`define MTT_SW 4
// fixed location used by the data-trace test
`define MTT_DATA_ADDR 8'h00
// read wait, loaded as the rd strobe goes out: one memory turn, three
// synchroniser flops and the agree stage must pass before data are trusted
`define MTT_RD_WAIT 3'h5
`define MTT_WAIT_ZERO 3'h0
`define MTT_WAIT_ONE 3'h1
// reset values and walk constants
`define MTT_ZERO_D 8'h00
`define MTT_ZERO_A 8'h00
`define MTT_ZERO_S 4'h0
`define MTT_ONE_D 8'h01
`define MTT_TOP_D 8'h80
`define MTT_LAST_BIT 4'h7
`define MTT_LAST_ADDR_STEP 4'h8
`define MTT_ONE_S 4'h1

`endif

// [src/mtt_pkg.sv]
package mtt_pkg;
  `include "mtt_defines.svh"

  // ******************************
  // types
  // ******************************
  typedef enum logic [2:0] {
    MTT_IDLE = 3'b000,
    MTT_DWR = 3'b001,
    MTT_DRD = 3'b010,
    MTT_AWR = 3'b011,
    MTT_ARD = 3'b100,
    MTT_DONE = 3'b101
  } mtt_state_t;

  // memory request carried as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`MTT_AW-1:0] addr;
    logic [`MTT_DW-1:0] wdata;
  } mtt_req_t;

  // result report
  typedef struct packed {
    logic done;
    logic pass;
    logic data_fail;
    logic addr_fail;
    logic [`MTT_SW-1:0] fail_step;
    logic [`MTT_DW-1:0] fail_bits;
  } mtt_rpt_t;
endpackage : mtt_pkg

// [src/mtt_sync.sv]
`timescale 1ns/1ps
`include "mtt_defines.svh"
// ******************************
// three-stage input synchroniser; value moves on when stages 2 and 3 agree
// ******************************
module mtt_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`MTT_DW-1:0] din,
  output logic [`MTT_DW-1:0] dout
);
  logic [`MTT_DW-1:0] s1_r;
  logic [`MTT_DW-1:0] s2_r;
  logic [`MTT_DW-1:0] s3_r;
  logic [`MTT_DW-1:0] q_r;

  // one lane per bit; stage 1 feeds only stage 2
  genvar g;
  for (g = 0; g < `MTT_DW; g++) begin : g_bit
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
        s3_r[g] <= 1'b0;
        q_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= din[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          q_r[g] <= s3_r[g];
        end
      end
    end
  end

  assign dout = q_r;
endmodule : mtt_sync

// [src/mtt_tester.sv]
`timescale 1ns/1ps
`include "mtt_defines.svh"
// Function
// - walk a single one across data bits
// - each data pattern has one bit set
// - walk order selectable, up or down
// - data test uses one fixed address
// - write, read back, advance only on match
// - flag bit failure on data mismatch
// - all address writes before any reads
// - address locations are zero and the powers of two
// - unique value per address location
module mtt_tester
  import mtt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic walk_down,
  output mtt_req_t mem_req,
  input wire logic [`MTT_DW-1:0] mem_rdata,
  output mtt_rpt_t report
);

  // ******************************
  // state
  // ******************************
  mtt_state_t state_r;
  mtt_state_t state_nxt;
  logic [`MTT_DW-1:0] pat_r;
  logic [`MTT_SW-1:0] step_r;
  logic [2:0] wait_r;
  logic rd_pend_r;
  logic dir_r;
  mtt_req_t req_r;
  mtt_rpt_t rpt_r;
  logic [`MTT_DW-1:0] rd_sync;
  logic rd_ok;
  logic [`MTT_DW-1:0] expect_d;
  logic [`MTT_AW-1:0] loc_addr;
  logic [`MTT_DW-1:0] loc_val;
  logic last_data;
  logic last_addr;

  // read data arrive from pins, so they pass the synchroniser; this costs
  // four edges of latency, which the read wait below must cover, but keeps
  // a trace that floats or rings from upsetting the compare
  mtt_sync u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din(mem_rdata),
    .dout(rd_sync)
  );

  // ******************************
  // pattern helpers
  // ******************************
  // step 0 is address zero, step k is address bit k-1 alone
  assign loc_addr = (step_r == `MTT_ZERO_S) ? `MTT_ZERO_A :
    (`MTT_ONE_D << (step_r - `MTT_ONE_S));
  // consecutive integers starting at 1 keep every location distinct
  assign loc_val = `MTT_DW'(step_r) + `MTT_ONE_D;
  assign expect_d = (state_r == MTT_DRD) ? pat_r : loc_val;
  assign last_data = dir_r ? (pat_r == `MTT_ONE_D) : (pat_r == `MTT_TOP_D);
  assign last_addr = (step_r == `MTT_LAST_ADDR_STEP);
  // read data are sampled when the latency counter runs out; one edge
  // early would compare the previous read, or the bus left by the write,
  // and every pattern would look failed
  assign rd_ok = rd_pend_r && (wait_r == `MTT_WAIT_ZERO);

  // ******************************
  // sequencer
  // ******************************
  // data walk first, then all address writes, then all address reads;
  // start is looked at only while idle or done, never mid-run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MTT_IDLE: begin
        if (start) begin
          state_nxt = MTT_DWR;
        end
      end
      MTT_DWR: state_nxt = MTT_DRD;
      MTT_DRD: begin
        // a mismatch holds the step: retry until the trace reads right
        // limitation: a hard data fault never lets the run finish
        if (rd_ok && rd_sync == pat_r) begin
          state_nxt = last_data ? MTT_AWR : MTT_DWR;
        end else if (rd_ok) begin
          state_nxt = MTT_DWR;
        end
      end
      MTT_AWR: begin
        if (last_addr) begin
          state_nxt = MTT_ARD;
        end
      end
      MTT_ARD: begin
        if (rd_ok && last_addr) begin
          state_nxt = MTT_DONE;
        end
      end
      MTT_DONE: begin
        if (start) begin
          state_nxt = MTT_DWR;
        end
      end
      default: state_nxt = MTT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= MTT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ******************************
  // walking one and step counter
  // ******************************
  // the walking bit serves only the data test, one step count serves both tests; the step count
  // is cleared between them so address zero is always the first location
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pat_r <= `MTT_ONE_D;
      dir_r <= 1'b0;
      step_r <= `MTT_ZERO_S;
    end else if (state_r == MTT_IDLE || state_r == MTT_DONE) begin
      // order latched at start so it cannot change mid-walk
      dir_r <= walk_down;
      pat_r <= walk_down ? `MTT_TOP_D : `MTT_ONE_D;
      step_r <= `MTT_ZERO_S;
    end else if (state_r == MTT_DRD && rd_ok && rd_sync == pat_r) begin
      if (last_data) begin
        step_r <= `MTT_ZERO_S;
      end else begin
        pat_r <= dir_r ? (pat_r >> 1) : (pat_r << 1);
        step_r <= step_r + `MTT_ONE_S;
      end
    end else if (state_r == MTT_AWR) begin
      step_r <= last_addr ? `MTT_ZERO_S : step_r + `MTT_ONE_S;
    end else if (state_r == MTT_ARD && rd_ok && !last_addr) begin
      step_r <= step_r + `MTT_ONE_S;
    end
  end

  // ******************************
  // memory requests
  // ******************************
  // strobes last one cycle; address and data stay put until the next
  // request, so a slow memory still sees a settled address. a read
  // blocks further requests until its wait has run out
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= '0;
      rd_pend_r <= 1'b0;
      wait_r <= `MTT_WAIT_ZERO;
    end else begin
      req_r.wr <= 1'b0;
      req_r.rd <= 1'b0;
      if (state_r == MTT_DWR) begin
        req_r.wr <= 1'b1;
        req_r.addr <= `MTT_DATA_ADDR;
        req_r.wdata <= pat_r;
      end else if (state_r == MTT_AWR) begin
        req_r.wr <= 1'b1;
        req_r.addr <= loc_addr;
        req_r.wdata <= loc_val;
      end else if ((state_r == MTT_DRD || state_r == MTT_ARD) &&
                   !rd_pend_r) begin
        req_r.rd <= 1'b1;
        req_r.addr <= (state_r == MTT_DRD) ? `MTT_DATA_ADDR : loc_addr;
        rd_pend_r <= 1'b1;
        // covers the memory turn plus the whole synchroniser path; a
        // memory slower than one turn needs this count raised
        wait_r <= `MTT_RD_WAIT;
      end else if (rd_pend_r && wait_r != `MTT_WAIT_ZERO) begin
        wait_r <= wait_r - `MTT_WAIT_ONE;
      end else if (rd_ok) begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // ******************************
  // result report
  // ******************************
  // a new start wipes the old report; flags are sticky within a run so
  // a retrying data step cannot hide its first failure
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rpt_r <= '0;
    end else if ((state_r == MTT_IDLE || state_r == MTT_DONE) && start) begin
      rpt_r <= '0;
    end else begin
      if (rd_ok && (state_r == MTT_DRD || state_r == MTT_ARD) &&
          rd_sync != expect_d) begin
        // first failure kept; later ones only accumulate flags
        if (!rpt_r.data_fail && !rpt_r.addr_fail) begin
          rpt_r.fail_step <= step_r;
          rpt_r.fail_bits <= rd_sync ^ expect_d;
        end
        if (state_r == MTT_DRD) begin
          rpt_r.data_fail <= 1'b1;
        end else begin
          rpt_r.addr_fail <= 1'b1;
        end
      end
      if (state_r == MTT_ARD && state_nxt == MTT_DONE) begin
        rpt_r.done <= 1'b1;
        rpt_r.pass <= !rpt_r.data_fail && !rpt_r.addr_fail &&
          (rd_sync == expect_d);
      end
    end
  end

  assign mem_req = req_r;
  assign report = rpt_r;
endmodule : mtt_tester

// [testbench/mtt_mem_model.sv]
`timescale 1ns/1ps
// behavioural memory at the far end of the traces, with fault knobs
module mtt_mem_model
  import mtt_pkg::*;
(
  input wire logic sys_clk,
  input mtt_req_t mem_req,
  input wire logic [7:0] stuck,
  input wire logic alias_a1,
  output logic [7:0] rdata
);
  logic [7:0] mem [256];
  logic [7:0] a;
  initial rdata = 8'h5a;
  // a broken address trace drops bit 1, so two locations alias
  assign a = alias_a1 ? (mem_req.addr & 8'hfd) : mem_req.addr;
  // read data holds until the next request; a write scrambles the bus
  always @(posedge sys_clk) begin
    if (mem_req.wr) begin
      mem[a] <= mem_req.wdata;
      rdata <= ~rdata;
    end
    if (mem_req.rd) begin
      rdata <= mem[a] & ~stuck;
    end
  end
endmodule : mtt_mem_model

// [testbench/mtt_tester_sva.sv]
`timescale 1ns/1ps
module mtt_tester_sva
  import mtt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic walk_down,
  input mtt_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input mtt_rpt_t report
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic rd_seen_r;
  // remembers an address-test read within the current run
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_seen_r <= 1'b0;
    end else if (start) begin
      rd_seen_r <= 1'b0;
    end else if (mem_req.rd && mem_req.addr != 8'h00) begin
      rd_seen_r <= 1'b1;
    end
  end
  a_wr_onehot: assert property (
    mem_req.wr && mem_req.addr == 8'h00 |-> $onehot(mem_req.wdata))
    else $error("write at zero not one-hot");
  a_addr_pow2: assert property (
    mem_req.wr |-> mem_req.addr == 8'h00 || $onehot(mem_req.addr))
    else $error("write address not a power of two");
  a_wr_before_rd: assert property (
    mem_req.wr && mem_req.addr != 8'h00 |-> !rd_seen_r)
    else $error("address write after a read-back");
  a_rd_gap: assert property (mem_req.rd |=> !mem_req.rd [*4])
    else $error("reads closer than five cycles");
  a_rd_addr_hold: assert property (
    mem_req.rd |=> $stable(mem_req.addr))
    else $error("address moved after read");
  a_pass_match: assert property (
    report.done |-> report.pass == !(report.data_fail || report.addr_fail))
    else $error("pass disagrees with fail flags");
  a_fail_sticky: assert property (
    report.data_fail && !start |=> report.data_fail)
    else $error("data fail flag dropped");
  a_fail_bits: assert property (
    report.data_fail || report.addr_fail |-> report.fail_bits != 8'h00)
    else $error("fail bits empty on failure");
endmodule : mtt_tester_sva
bind mtt_tester mtt_tester_sva chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
  .start(start), .walk_down(walk_down), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .report(report));

// [testbench/test_memory_trace_tester.sv]
`timescale 1ns/1ps
module test_memory_trace_tester
  import mtt_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic walk_down = 1'b0;
  logic [7:0] stuck = 8'h00;
  logic alias_a1 = 1'b0;
  logic [7:0] mem_rdata;
  mtt_req_t mem_req;
  mtt_rpt_t report;
  logic [15:0] wlog[$];
  int error_cnt = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  mtt_tester dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .start(start),
    .walk_down(walk_down), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .report(report));
  mtt_mem_model mem_u (.sys_clk(sys_clk), .mem_req(mem_req),
    .stuck(stuck), .alias_a1(alias_a1), .rdata(mem_rdata));
  // log every write as address and data
  always @(posedge sys_clk) if (mem_req.wr) wlog.push_back(mem_req[15:0]);
  // ********************
  // shared tasks
  // ********************
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic run(logic wd, logic [7:0] st, logic al, logic want_done);
    int i;
    @(posedge sys_clk);
    #2 {walk_down, stuck, alias_a1, start} = {wd, st, al, 1'b1};
    wlog.delete();
    @(posedge sys_clk);
    #2 start = 1'b0;
    for (i = 0; i < 3000; i++) begin
      if (want_done ? report.done === 1'b1 : report.data_fail === 1'b1)
        break;
      @(posedge sys_clk);
    end
    if (i == 3000) begin
      check("run timeout", 16'h1, 16'h0);
      tally_and_finish();
    end
  endtask : run
  // ********************
  // scenarios
  // ********************
  task automatic t_clean(logic wd);
    int i;
    run(wd, 8'h00, 1'b0, 1'b1);
    check("pass", 16'h1, report.pass);
    check("writes", 16'h11, wlog.size());
    for (i = 0; i < 8; i++)
      check("data wr", wd ? 16'h80 >> i : 16'h1 << i, wlog[i]);
    for (i = 0; i < 9; i++)
      check("addr wr", {i ? 8'h1 << (i - 1) : 8'h0, 8'(i + 1)},
        wlog[8 + i]);
  endtask : t_clean
  task automatic t_alias();
    run(1'b0, 8'h00, 1'b1, 1'b1);
    check("addr fail", 16'h1, report.addr_fail);
    check("data fail", 16'h0, report.data_fail);
    check("pass", 16'h0, report.pass);
    check("step", 16'h0, report.fail_step);
    check("bits", 16'h2, report.fail_bits);
  endtask : t_alias
  task automatic t_stuck();
    int i;
    run(1'b0, 8'h02, 1'b0, 1'b0);
    check("data fail", 16'h1, report.data_fail);
    check("step", 16'h1, report.fail_step);
    check("bits", 16'h2, report.fail_bits);
    repeat (200) @(posedge sys_clk);
    check("done", 16'h0, report.done);
    for (i = 0; i < wlog.size(); i++)
      if (wlog[i][7:0] > 8'h02) check("advance", 16'h2, wlog[i]);
  endtask : t_stuck
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (16) @(posedge sys_clk);
    #2 arst_n = 1'b1;
    t_clean(1'b0);
    t_clean(1'b1);
    t_alias();
    t_stuck();
    tally_and_finish();
  end
endmodule : test_memory_trace_tester
